// [design/imec_top.sv]
`timescale 1ns/10ps
`default_nettype none
module imec_top
	import imec_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [25:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] irq_src,
	output logic core_irq,
	output logic irq_line
);
	logic [31:0] pend_r;
	logic [31:0] pend_nxt;
	logic [31:0] enable_r;
	logic [31:0] mode_r;
	logic [31:0] mask_r;
	logic [31:0] src_d_r;
	logic [31:0] clr_vec;
	logic [31:0] rdata_nxt;
	logic wr_acc;
	logic rd_acc;
	logic hit;
	logic [23:0] idx;
	logic core_irq_r;

	assign idx = paddr[IMEC_ADDR_W-1:2];
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign hit = (idx == IMEC_IDX_PEND_LOW) || (idx == IMEC_IDX_PEND_HIGH) || (idx == IMEC_IDX_EN_LOW)
		|| (idx == IMEC_IDX_EN_HIGH) || (idx == IMEC_IDX_CLR_LOW) || (idx == IMEC_IDX_CLR_HIGH)
		|| (idx == IMEC_IDX_MODE_LOW) || (idx == IMEC_IDX_MODE_HIGH)
		|| (idx == IMEC_IDX_MASK_LOW) || (idx == IMEC_IDX_MASK_HIGH);
	// Unmapped or misaligned access answers with an error, no side effect
	assign pslverr = psel && penable && (!hit || (paddr[1:0] != 2'b00));

	// Enable registers, low half-word byte lanes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= {IMEC_EN_RST, IMEC_EN_RST};
		end else if (wr_acc && !pslverr) begin
			if (idx == IMEC_IDX_EN_LOW) begin
				if (pstrb[0]) enable_r[7:0] <= pwdata[7:0];
				if (pstrb[1]) enable_r[15:8] <= pwdata[15:8];
			end
			if (idx == IMEC_IDX_EN_HIGH) begin
				if (pstrb[0]) enable_r[23:16] <= pwdata[7:0];
				if (pstrb[1]) enable_r[31:24] <= pwdata[15:8];
			end
		end
	end

	// Trigger mode per request: 1 edge, 0 level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= {IMEC_MODE_RST, IMEC_MODE_RST};
		end else if (wr_acc && !pslverr) begin
			if (idx == IMEC_IDX_MODE_LOW) begin
				if (pstrb[0]) mode_r[7:0] <= pwdata[7:0];
				if (pstrb[1]) mode_r[15:8] <= pwdata[15:8];
			end
			if (idx == IMEC_IDX_MODE_HIGH) begin
				if (pstrb[0]) mode_r[23:16] <= pwdata[7:0];
				if (pstrb[1]) mode_r[31:24] <= pwdata[15:8];
			end
		end
	end

	// Interrupt output mask, same layout as pending
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= 32'h00000000;
		end else if (wr_acc && !pslverr) begin
			if (idx == IMEC_IDX_MASK_LOW) begin
				if (pstrb[0]) mask_r[7:0] <= pwdata[7:0];
				if (pstrb[1]) mask_r[15:8] <= pwdata[15:8];
			end
			if (idx == IMEC_IDX_MASK_HIGH) begin
				if (pstrb[0]) mask_r[23:16] <= pwdata[7:0];
				if (pstrb[1]) mask_r[31:24] <= pwdata[15:8];
			end
		end
	end

	// Write-one-to-clear vector from the edge-clear registers
	always_comb begin
		clr_vec = 32'h00000000;
		if (wr_acc && !pslverr && (idx == IMEC_IDX_CLR_LOW)) begin
			clr_vec[15:0] = pwdata[15:0] & IMEC_LOW_USED & {{8{pstrb[1]}}, {8{pstrb[0]}}};
		end
		if (wr_acc && !pslverr && (idx == IMEC_IDX_CLR_HIGH)) begin
			clr_vec[31:16] = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
		end
	end

	// Pending: edges are sticky and a new edge beats a same-cycle clear; levels follow the source
	always_comb begin
		pend_nxt = pend_r;
		for (int i = 0; i < 32; i++) begin
			if (mode_r[i]) begin
				if (irq_src[i] && !src_d_r[i]) begin
					pend_nxt[i] = 1'b1;
				end else if (clr_vec[i]) begin
					pend_nxt[i] = 1'b0;
				end
			end else begin
				pend_nxt[i] = irq_src[i];
			end
		end
		pend_nxt[IMEC_UNUSED_BIT] = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 32'h00000000;
			src_d_r <= 32'h00000000;
		end else begin
			pend_r <= pend_nxt;
			src_d_r <= irq_src;
		end
	end

	// Core request registered; request 0 is excluded whatever its enable says
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_irq_r <= 1'b0;
		end else begin
			core_irq_r <= |(pend_r & enable_r & {IMEC_LOW_USED | 16'hffff, IMEC_LOW_USED});
		end
	end
	assign core_irq = core_irq_r;
	assign irq_line = |(pend_r & mask_r);

	// Read mux
	always_comb begin
		rdata_nxt = 32'h00000000;
		case (idx)
			IMEC_IDX_PEND_LOW: rdata_nxt[15:0] = pend_r[15:0];
			IMEC_IDX_PEND_HIGH: rdata_nxt[15:0] = pend_r[31:16];
			IMEC_IDX_EN_LOW: rdata_nxt[15:0] = enable_r[15:0];
			IMEC_IDX_EN_HIGH: rdata_nxt[15:0] = enable_r[31:16];
			IMEC_IDX_CLR_LOW: rdata_nxt[15:0] = IMEC_CLR_READ;
			IMEC_IDX_CLR_HIGH: rdata_nxt[15:0] = IMEC_CLR_READ;
			IMEC_IDX_MODE_LOW: rdata_nxt[15:0] = mode_r[15:0];
			IMEC_IDX_MODE_HIGH: rdata_nxt[15:0] = mode_r[31:16];
			IMEC_IDX_MASK_LOW: rdata_nxt[15:0] = mask_r[15:0];
			IMEC_IDX_MASK_HIGH: rdata_nxt[15:0] = mask_r[31:16];
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	// Read data captured in setup so it is stable through the zero-wait access phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_nxt;
		end
	end

	a_clr_read_ffff: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && (idx == IMEC_IDX_CLR_LOW || idx == IMEC_IDX_CLR_HIGH))
		|=> (prdata == 32'h0000ffff))
		else $error("edge clear read not ffff");

	a_enable_write_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_acc && !pslverr && idx == IMEC_IDX_EN_LOW && pstrb == 4'hf) |=> (enable_r[15:0] == $past(pwdata[15:0])))
		else $error("enable low write lost");

	a_enable_write_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_acc && !pslverr && idx == IMEC_IDX_EN_HIGH && pstrb == 4'hf) |=> (enable_r[31:16] == $past(pwdata[15:0])))
		else $error("enable high write lost");

	a_bit0_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((pend_r[31:1] & enable_r[31:1]) == 31'h0) |=> !core_irq)
		else $error("request 0 reached core");

	a_edge_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_r[5] && clr_vec[5] && !(irq_src[5] && !src_d_r[5])) |=> !pend_r[5])
		else $error("edge clear failed");

	a_clr_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clr_vec[0] == 1'b0)
		else $error("reserved clear bit acted");

	a_high_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_acc && !pslverr && idx == IMEC_IDX_CLR_HIGH && pstrb[0] && pwdata[0] && mode_r[16] && !irq_src[16])
		|=> !pend_r[16])
		else $error("high clear mapping wrong");

	a_level_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!mode_r[9]) |=> (pend_r[9] == $past(irq_src[9])))
		else $error("level pending disturbed");

	a_status_bit0: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && idx == IMEC_IDX_PEND_LOW) |=> (prdata[0] == 1'b0))
		else $error("status bit 0 not zero");

	a_core_request: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(|(pend_r[31:1] & enable_r[31:1])) |=> core_irq)
		else $error("core request missing");

	// Named steps shared by the register and clear checks
	sequence s_read_setup(logic [23:0] sel_idx);
		psel && !penable && !pwrite && (idx == sel_idx);
	endsequence

	sequence s_clr_write_bit(logic [23:0] sel_idx, int n);
		wr_acc && !pslverr && (idx == sel_idx) && (pstrb == 4'hf) && pwdata[n];
	endsequence

	// A fresh edge in the clear cycle wins, so clear checks exclude it
	sequence s_no_new_edge(int n);
		!(irq_src[n] && !src_d_r[n]);
	endsequence

	sequence s_edge_on_enabled_top;
		mode_r[31] && enable_r[31] && irq_src[31] && !src_d_r[31];
	endsequence

	a_clr_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_CLR_LOW)
		|=> (prdata == {16'h0000, IMEC_CLR_READ}))
		else $error("edge clear low read not ffff");

	a_clr_high_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_CLR_HIGH)
		|=> (prdata == {16'h0000, IMEC_CLR_READ}))
		else $error("edge clear high read not ffff");

	a_en_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_EN_LOW)
		|=> (prdata == {16'h0000, $past(enable_r[15:0])}))
		else $error("enable low read wrong");

	a_en_high_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_EN_HIGH)
		|=> (prdata == {16'h0000, $past(enable_r[31:16])}))
		else $error("enable high read wrong");

	a_en_strobe_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_acc && !pslverr && (idx == IMEC_IDX_EN_LOW) && (pstrb == 4'h1))
		|=> (enable_r[15:8] == $past(enable_r[15:8])))
		else $error("unstrobed enable lane changed");

	a_pend_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_PEND_LOW)
		|=> (prdata == {16'h0000, $past(pend_r[15:1]), 1'b0}))
		else $error("pending low read wrong");

	a_pend_high_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_read_setup(IMEC_IDX_PEND_HIGH)
		|=> (prdata == {16'h0000, $past(pend_r[31:16])}))
		else $error("pending high read wrong");

	a_pend_bit0: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pend_r[IMEC_UNUSED_BIT] == 1'b0)
		else $error("pending bit 0 set");

	a_edge_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_r[5] && pend_r[5] && !clr_vec[5])
		|=> pend_r[5])
		else $error("edge pending lost without clear");

	a_set_beats_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_r[5] && clr_vec[5] && irq_src[5] && !src_d_r[5])
		|=> pend_r[5])
		else $error("clear beat a new edge");

	a_low_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_clr_write_bit(IMEC_IDX_CLR_LOW, 7) ##0 mode_r[7] ##0 s_no_new_edge(7)
		|=> !pend_r[7])
		else $error("low clear mapping wrong");

	a_high_top_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_clr_write_bit(IMEC_IDX_CLR_HIGH, 15) ##0 mode_r[31] ##0 s_no_new_edge(31)
		|=> !pend_r[31])
		else $error("high clear top bit wrong");

	a_level_clr_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_clr_write_bit(IMEC_IDX_CLR_LOW, 9) ##0 !mode_r[9]
		|=> (pend_r[9] == $past(irq_src[9])))
		else $error("clear disturbed a level request");

	// Registered request costs one cycle after pending
	a_core_two_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_edge_on_enabled_top
		|=> pend_r[31] ##1 core_irq)
		else $error("core request not two steps after edge");

	a_prdata_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	a_pready_zero_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(psel && penable)
		|-> pready)
		else $error("access phase without ready");
endmodule // imec_top
`default_nettype wire

// [design/imec_pkg.sv]
package imec_pkg;
	// Printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
	localparam logic [23:0] IMEC_IDX_PEND_LOW = 24'h00fe0a;
	localparam logic [23:0] IMEC_IDX_PEND_HIGH = 24'h00fe0c;
	localparam logic [23:0] IMEC_IDX_EN_LOW = 24'h00fe0e;
	localparam logic [23:0] IMEC_IDX_EN_HIGH = 24'h00fe10;
	localparam logic [23:0] IMEC_IDX_CLR_LOW = 24'h00fe12;
	localparam logic [23:0] IMEC_IDX_CLR_HIGH = 24'h00fe14;
	localparam logic [23:0] IMEC_IDX_MODE_LOW = 24'h00fe16;
	localparam logic [23:0] IMEC_IDX_MODE_HIGH = 24'h00fe18;
	localparam logic [23:0] IMEC_IDX_MASK_LOW = 24'h00fe1a;
	localparam logic [23:0] IMEC_IDX_MASK_HIGH = 24'h00fe1c;
	localparam int IMEC_ADDR_W = 26;
	localparam int IMEC_REG_W = 16;
	localparam logic [15:0] IMEC_EN_RST = 16'h0000;
	localparam logic [15:0] IMEC_MODE_RST = 16'h0000;
	localparam logic [15:0] IMEC_CLR_READ = 16'hffff;
	localparam logic [15:0] IMEC_LOW_USED = 16'hfffe;
	localparam int IMEC_UNUSED_BIT = 0;
endpackage

// [bench/imec_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
module imec_src_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] want,
	output logic [31:0] irq_src
);
	// Sources move just after the edge, as a synchronous peripheral would
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) irq_src <= 32'h0;
		else irq_src <= want;
	end
endmodule // imec_src_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import imec_pkg::*;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [25:0] paddr = '0;
	logic [31:0] pwdata = '0, want = '0, prdata, irq_src, rd, r, c, p;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, core_irq, irq_line, err;
	int bad_count = 0, checks_done = 0, cyc = 0;
	imec_top imec_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_src(irq_src), .core_irq(core_irq), .irq_line(irq_line));
	imec_src_model imec_src_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .want(want), .irq_src(irq_src));
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task stop_test;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Master holds the request until pready is seen high at an edge
	task apb(input logic w, input logic [23:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdpend;
		apb(1'b0, IMEC_IDX_PEND_LOW, 32'h0);
		p[15:0] = rd[15:0];
		apb(1'b0, IMEC_IDX_PEND_HIGH, 32'h0);
		p[31:16] = rd[15:0];
	endtask
	// Pulse then settle; edge to pending to core request spans three edges
	task pulse(input logic [31:0] v);
		@(posedge sys_clk);
		want <= v;
		repeat (3) @(posedge sys_clk);
		want <= 32'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		r = $urandom(32'he9583c14);
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(0, IMEC_IDX_EN_LOW, 0);
		chk(rd, {16'h0, IMEC_EN_RST});
		apb(0, IMEC_IDX_EN_HIGH, 0);
		chk(rd, {16'h0, IMEC_EN_RST});
		apb(0, IMEC_IDX_CLR_LOW, 0);
		chk(rd, 32'h0000ffff);
		apb(0, 24'h00fe20, 0);
		chk({31'h0, err}, 32'h1);
		repeat (4) begin
			r = $urandom;
			apb(1, IMEC_IDX_EN_LOW, {16'h0, r[15:0]});
			apb(1, IMEC_IDX_EN_HIGH, {16'h0, r[31:16]});
			apb(0, IMEC_IDX_EN_LOW, 0);
			chk(rd, {16'h0, r[15:0]});
			apb(0, IMEC_IDX_EN_HIGH, 0);
			chk(rd, {16'h0, r[31:16]});
		end
		apb(1, IMEC_IDX_MODE_LOW, 32'hffff);
		apb(1, IMEC_IDX_MODE_HIGH, 32'hffff);
		apb(1, IMEC_IDX_CLR_LOW, 32'hffff);
		apb(1, IMEC_IDX_CLR_HIGH, 32'hffff);
		apb(1, IMEC_IDX_EN_LOW, 0);
		apb(1, IMEC_IDX_EN_HIGH, 0);
		repeat (3) begin
			r = $urandom | 32'h1;
			pulse(r);
			rdpend();
			chk(p, r & 32'hfffffffe);
			chk({31'h0, core_irq}, 32'h0);
			chk({31'h0, irq_line}, 32'h0);
			c = $urandom;
			apb(1, IMEC_IDX_CLR_LOW, {16'h0, c[15:0]});
			apb(1, IMEC_IDX_CLR_HIGH, {16'h0, c[31:16]});
			rdpend();
			chk(p, r & ~c & 32'hfffffffe);
			apb(0, IMEC_IDX_CLR_HIGH, 0);
			chk(rd, 32'h0000ffff);
			apb(1, IMEC_IDX_CLR_LOW, 32'hffff);
			apb(1, IMEC_IDX_CLR_HIGH, 32'hffff);
		end
		apb(1, IMEC_IDX_EN_LOW, 32'h1);
		pulse(32'h1);
		chk({31'h0, core_irq}, 32'h0);
		apb(1, IMEC_IDX_EN_HIGH, 32'h8000);
		apb(1, IMEC_IDX_MASK_HIGH, 32'h8000);
		pulse(32'h80000000);
		chk({31'h0, core_irq}, 32'h1);
		chk({31'h0, irq_line}, 32'h1);
		apb(1, IMEC_IDX_CLR_HIGH, 32'h8000);
		repeat (2) @(posedge sys_clk);
		#1;
		chk({31'h0, core_irq}, 32'h0);
		chk({31'h0, irq_line}, 32'h0);
		apb(1, IMEC_IDX_MODE_LOW, 32'hfffb);
		want <= 32'h4;
		apb(1, IMEC_IDX_CLR_LOW, 32'h4);
		rdpend();
		chk(p, 32'h4);
		stop_test();
	end
endmodule // testbench
`default_nettype wire
